/* rtl/decode_pkg.sv */
// Summary of operation
// - 24-bit word, top 8 bits opcode
// - exactly three opcodes span two words
// - second word top byte zero, NOP
// - lone second word changes nothing but PC
// - d=0 writes W0, d=1 file register
// - file address covers 0 to 0x1FFF
// - true condition or PC change adds cycle
// - listed control opcodes always two cycles
// - taken skip: two or three cycles
// - two-word instructions take two cycles
// - instruction cycle is four oscillator periods
// - bit select 3 bits byte, 4 word
// - unsigned ten-bit operand byte limit 255
// - program address operand must be even
// - signed operands at 5, 10, 16 bits
// - MAC write-back only to W13
// - five integer flags, four accumulator flags
// - word default; byte, double, shadow modes
// - MAC fields: acc, pair, prefetch, write-back
package decode_pkg;
    // ------------------------------------------------
    // Word layout
    // ------------------------------------------------
    localparam int WORD_W = 24;
    localparam int OPC_HI = 23;
    localparam int OPC_LO = 16;
    localparam logic [7:0] OPC_NOP = 8'h00;
    localparam int N_TWO = 3;
    localparam logic [7:0] OPC_TWO [N_TWO] = '{8'h02, 8'h04, 8'h0B};
    localparam int N_ALW = 8;
    localparam logic [7:0] OPC_ALW [N_ALW] =
        '{8'h01, 8'h37, 8'h38, 8'hBA, 8'hBB, 8'h05, 8'h06, 8'hFE};
    localparam int N_SKIP = 4;
    localparam logic [7:0] OPC_SKIP [N_SKIP] = '{8'hA6, 8'hA7, 8'hE6, 8'hE7};
    localparam int MODE_HI = 15;
    localparam int MODE_LO = 14;
    localparam int D_BIT = 13;
    localparam int F_HI = 12;
    localparam int B3_HI = 2;
    localparam int B4_HI = 3;
    localparam int U10_HI = 13;
    localparam int U10_LO = 4;
    localparam logic [9:0] U10_BYTE_MAX = 10'h0FF;
    localparam int S5_HI = 4;
    localparam int S16_HI = 15;
    localparam int W2_ADDR_HI = 6;
    localparam int ACC_BIT = 15;
    localparam int PAIR_HI = 14;
    localparam int PAIR_LO = 12;
    localparam int XOP_HI = 11;
    localparam int XOP_LO = 9;
    localparam int XD_HI = 8;
    localparam int XD_LO = 7;
    localparam int YOP_HI = 6;
    localparam int YOP_LO = 4;
    localparam int YD_HI = 3;
    localparam int YD_LO = 2;
    localparam int MWR_HI = 1;
    localparam logic [1:0] MWR_NONE = 2'h0;
    localparam logic [1:0] MWR_DIRECT = 2'h1;
    localparam logic [1:0] MWR_POSTINC = 2'h2;
    localparam logic [3:0] MAC_WR_REG = 4'hD;
    localparam logic [3:0] DEF_DEFAULT_WORK_REGISTER = 4'h0;
    // ------------------------------------------------
    // Timing and registers
    // ------------------------------------------------
    localparam int OSC_PER_CYC = 4;
    localparam logic [1:0] PH_LAST = 2'(OSC_PER_CYC - 1);
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] FLAG_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic CTRL_RST = 1'b1;
    localparam int ZERO_IDX = 4;

    typedef enum logic [1:0] {
        MODE_WORD = 2'h0, MODE_BYTE = 2'h1, MODE_DBL = 2'h2, MODE_SHADOW = 2'h3
    } mode_t;

    typedef enum logic [4:0] {
        ST_FETCH = 5'h01, ST_WORD2 = 5'h02, ST_FLUSH = 5'h04,
        ST_SKIP = 5'h08, ST_SKIP2 = 5'h10
    } state_t;

    typedef struct packed {
        logic acc_b_clamped_flag;
        logic acc_a_clamped_flag;
        logic acc_b_overflow_flag;
        logic acc_a_overflow_flag;
        logic sticky_zero_flag;
        logic signed_wrap_flag;
        logic negative;
        logic nibble_carry_flag;
        logic carry;
    } flags_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic two_word;
        logic nop;
        mode_t mode;
        logic dest_file;
        logic [3:0] default_work_register;
        logic [12:0] file_addr;
        logic [3:0] bit_sel;
        logic [9:0] ten_bit_unsigned_operand;
        logic err_range;
        logic [15:0] s5_ext;
        logic [15:0] ten_bit_signed_operand;
        logic [15:0] s16;
        logic [22:0] program_address_operand;
        logic err_addr;
        logic acc_b;
        logic [2:0] mul_pair;
        logic [2:0] x_op;
        logic [1:0] x_dst;
        logic [2:0] y_op;
        logic [1:0] y_dst;
        logic mac_wr_en;
        logic mac_wr_inc;
        logic [3:0] mac_result_writeback_reg;
        logic err_mac;
    } dec_t;
endpackage : decode_pkg

/* rtl/instr_decode.sv */
`timescale 1ns/1ns
`default_nettype none
module instr_decode #(
    parameter int ADDR_W = 8
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [decode_pkg::WORD_W-1:0] word_i,
    output logic fetch_o,
    input wire logic cond_true_i,
    input wire logic pc_change_i,
    input wire decode_pkg::flags_t flag_val_i,
    input wire decode_pkg::flags_t flag_we_i,
    output logic cyc_stb_o,
    output logic [1:0] phase_o,
    output logic issue_o,
    output var decode_pkg::dec_t dec_o,
    output logic nop_o,
    output logic done_o,
    output logic [1:0] cycles_o,
    output var decode_pkg::flags_t flags_o,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);
    // Offsets must fit the address bus
    if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W out of range");
    end

    // ------------------------------------------------
    // Instruction cycle timing
    // ------------------------------------------------
    logic [1:0] phase_q;
    logic cyc_stb;
    logic run_q;
    decode_pkg::state_t state_q;
    decode_pkg::state_t st_d;

    // One strobe per four oscillator clocks
    assign cyc_stb = (phase_q == decode_pkg::PH_LAST);

    // Free running phase, cleared by reset
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    // ------------------------------------------------
    // Opcode classes
    // ------------------------------------------------
    logic [7:0] opc;
    logic [decode_pkg::N_TWO-1:0] hit_two;
    logic [decode_pkg::N_ALW-1:0] hit_alw;
    logic [decode_pkg::N_SKIP-1:0] hit_skip;
    logic is_two;
    logic is_alw;
    logic is_skip;

    assign opc = word_i[decode_pkg::OPC_HI:decode_pkg::OPC_LO];

    // Set membership, one compare per entry
    for (genvar i = 0; i < decode_pkg::N_TWO; i++) begin : g_two
        assign hit_two[i] = (opc == decode_pkg::OPC_TWO[i]);
    end
    for (genvar i = 0; i < decode_pkg::N_ALW; i++) begin : g_alw
        assign hit_alw[i] = (opc == decode_pkg::OPC_ALW[i]);
    end
    for (genvar i = 0; i < decode_pkg::N_SKIP; i++) begin : g_skip
        assign hit_skip[i] = (opc == decode_pkg::OPC_SKIP[i]);
    end
    assign is_two = |hit_two;
    assign is_alw = |hit_alw;
    assign is_skip = |hit_skip;

    // ------------------------------------------------
    // Sequencer
    // ------------------------------------------------
    logic take_first;

    // A word is consumed on every strobe except flush and halt
    assign take_first = cyc_stb && (state_q == decode_pkg::ST_FETCH) && run_q;
    assign fetch_o = take_first || (cyc_stb && (state_q == decode_pkg::ST_WORD2
        || state_q == decode_pkg::ST_SKIP || state_q == decode_pkg::ST_SKIP2));

    // Next state only moves on a strobe
    always_comb begin
        st_d = state_q;
        if (cyc_stb) begin
            case (state_q)
                decode_pkg::ST_FETCH: begin
                    if (!run_q) begin
                        st_d = decode_pkg::ST_FETCH;
                    end else if (is_two) begin
                        st_d = decode_pkg::ST_WORD2;
                    end else if (is_skip && cond_true_i) begin
                        st_d = decode_pkg::ST_SKIP;
                    end else if (is_alw || cond_true_i || pc_change_i) begin
                        st_d = decode_pkg::ST_FLUSH;
                    end
                end
                decode_pkg::ST_SKIP: begin
                    // Skipped word may itself be two words long
                    st_d = is_two ? decode_pkg::ST_SKIP2 : decode_pkg::ST_FETCH;
                end
                default: st_d = decode_pkg::ST_FETCH;
            endcase
        end
    end

    // State register
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= decode_pkg::ST_FETCH;
        end else begin
            state_q <= st_d;
        end
    end

    // ------------------------------------------------
    // Field extraction
    // ------------------------------------------------
    decode_pkg::dec_t dec_w;
    decode_pkg::dec_t dec_q;
    logic byte_m;
    logic [1:0] mwr;

    assign byte_m = (word_i[decode_pkg::MODE_HI:decode_pkg::MODE_LO] == decode_pkg::MODE_BYTE);
    assign mwr = word_i[decode_pkg::MWR_HI:0];

    // Every field decoded in parallel; the opcode picks what is meaningful
    always_comb begin
        dec_w = '0;
        dec_w.opcode = opc;
        dec_w.two_word = is_two;
        dec_w.nop = (opc == decode_pkg::OPC_NOP);
        // No suffix bits set gives word mode
        dec_w.mode = decode_pkg::mode_t'(word_i[decode_pkg::MODE_HI:decode_pkg::MODE_LO]);
        dec_w.dest_file = word_i[decode_pkg::D_BIT];
        dec_w.default_work_register = decode_pkg::DEF_DEFAULT_WORK_REGISTER;
        dec_w.file_addr = word_i[decode_pkg::F_HI:0];
        dec_w.bit_sel = byte_m ? {1'b0, word_i[decode_pkg::B3_HI:0]}
                               : word_i[decode_pkg::B4_HI:0];
        dec_w.ten_bit_unsigned_operand = word_i[decode_pkg::U10_HI:decode_pkg::U10_LO];
        dec_w.err_range = byte_m && (word_i[decode_pkg::U10_HI:decode_pkg::U10_LO]
                          > decode_pkg::U10_BYTE_MAX);
        dec_w.s5_ext = 16'($signed(word_i[decode_pkg::S5_HI:0]));
        dec_w.ten_bit_signed_operand =
            16'($signed(word_i[decode_pkg::U10_HI:decode_pkg::U10_LO]));
        dec_w.s16 = word_i[decode_pkg::S16_HI:0];
        dec_w.program_address_operand = 23'(word_i[decode_pkg::S16_HI:0]);
        dec_w.err_addr = word_i[0];
        dec_w.acc_b = word_i[decode_pkg::ACC_BIT];
        dec_w.mul_pair = word_i[decode_pkg::PAIR_HI:decode_pkg::PAIR_LO];
        dec_w.x_op = word_i[decode_pkg::XOP_HI:decode_pkg::XOP_LO];
        dec_w.x_dst = word_i[decode_pkg::XD_HI:decode_pkg::XD_LO];
        dec_w.y_op = word_i[decode_pkg::YOP_HI:decode_pkg::YOP_LO];
        dec_w.y_dst = word_i[decode_pkg::YD_HI:decode_pkg::YD_LO];
        // Only W13 can receive the write-back
        dec_w.mac_wr_en = (mwr == decode_pkg::MWR_DIRECT) || (mwr == decode_pkg::MWR_POSTINC);
        dec_w.mac_wr_inc = (mwr == decode_pkg::MWR_POSTINC);
        dec_w.mac_result_writeback_reg = decode_pkg::MAC_WR_REG;
        dec_w.err_mac = !dec_w.mac_wr_en && (mwr != decode_pkg::MWR_NONE);
    end

    // ------------------------------------------------
    // Decoded instruction and cycle accounting
    // ------------------------------------------------
    logic issue_q;
    logic done_q;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic [1:0] cycles_q;

    // First strobe of an instruction restarts the count
    assign cnt_d = (state_q == decode_pkg::ST_FETCH) ? 2'h1 : cnt_q + 2'h1;

    // Two-word forms issue only once the address is complete
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dec_q <= '0;
            issue_q <= 1'b0;
        end else begin
            issue_q <= (take_first && !is_two)
                || (cyc_stb && state_q == decode_pkg::ST_WORD2);
            if (take_first) begin
                dec_q <= dec_w;
            end else if (cyc_stb && state_q == decode_pkg::ST_WORD2) begin
                dec_q.program_address_operand[22:16] <=
                    word_i[decode_pkg::W2_ADDR_HI:0];
            end
        end
    end

    // Completion pulse carries the cycles spent
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 2'h0;
            cycles_q <= 2'h0;
            done_q <= 1'b0;
        end else begin
            done_q <= cyc_stb && (st_d == decode_pkg::ST_FETCH)
                && !(state_q == decode_pkg::ST_FETCH && !run_q);
            if (cyc_stb && !(state_q == decode_pkg::ST_FETCH && !run_q)) begin
                cnt_q <= cnt_d;
                cycles_q <= cnt_d;
            end
        end
    end

    // Extra, skipped and lone second-word cycles do nothing
    assign nop_o = !run_q || dec_q.nop || (state_q == decode_pkg::ST_FLUSH)
        || (state_q == decode_pkg::ST_SKIP) || (state_q == decode_pkg::ST_SKIP2);

    // ------------------------------------------------
    // APB slave
    // ------------------------------------------------
    logic apb_setup;
    logic apb_acc;
    logic hit_ctrl;
    logic hit_flag;
    logic hit_stat;
    logic wr_ctrl;
    logic wr_flag;
    logic [31:0] rd_mux;
    logic [31:0] prdata_q;
    logic [8:0] flags_q;

    assign apb_setup = psel_i && !penable_i;
    assign apb_acc = psel_i && penable_i;
    assign hit_ctrl = (paddr_i == ADDR_W'(decode_pkg::CTRL_OFS));
    assign hit_flag = (paddr_i == ADDR_W'(decode_pkg::FLAG_OFS));
    assign hit_stat = (paddr_i == ADDR_W'(decode_pkg::STAT_OFS));
    assign wr_ctrl = apb_acc && pwrite_i && hit_ctrl;
    assign wr_flag = apb_acc && pwrite_i && hit_flag;
    assign pready_o = 1'b1;
    assign pslverr_o = apb_acc && !(hit_ctrl || hit_flag || hit_stat);

    // Read mux, unmapped reads zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_mux = 32'(run_q);
        end else if (hit_flag) begin
            rd_mux = 32'(flags_q);
        end else if (hit_stat) begin
            rd_mux = {13'h0000, dec_q.err_mac, dec_q.err_addr, dec_q.err_range,
                      cycles_q, 1'b0, state_q, dec_q.opcode};
        end
    end

    // Data latched in setup so access is zero wait
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_q <= 32'h0000_0000;
            run_q <= decode_pkg::CTRL_RST;
        end else begin
            if (apb_setup) begin
                prdata_q <= rd_mux;
            end
            if (wr_ctrl) begin
                run_q <= pwdata_i[0];
            end
        end
    end

    // ------------------------------------------------
    // Status flags
    // ------------------------------------------------
    logic [8:0] flags_d;
    logic [8:0] fwe;

    // No-op cycles may not touch the flags
    assign fwe = flag_we_i & {9{!nop_o}};

    // Datapath update wins over a software write in the same cycle
    for (genvar i = 0; i < 9; i++) begin : g_flag
        if (i == decode_pkg::ZERO_IDX) begin : g_sticky
            // A result can only clear sticky zero; a software write can set or clear it
            assign flags_d[i] = fwe[i] ? (flags_q[i] & flag_val_i[i])
                : (wr_flag ? pwdata_i[i] : flags_q[i]);
        end else begin : g_plain
            assign flags_d[i] = fwe[i] ? flag_val_i[i]
                : (wr_flag ? pwdata_i[i] : flags_q[i]);
        end
    end

    // Flag register
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_q <= 9'h000;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign cyc_stb_o = cyc_stb;
    assign phase_o = phase_q;
    assign issue_o = issue_q;
    assign dec_o = dec_q;
    assign done_o = done_q;
    assign cycles_o = cycles_q;
    assign flags_o = decode_pkg::flags_t'(flags_q);
    assign prdata_o = prdata_q;

    // ------------------------------------------------
    // Checks
    // ------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    AST_CYC_FOUR: assert property (
        cyc_stb |=> !cyc_stb [*3] ##1 cyc_stb
    ) else $error("instruction strobe not every four clocks");

    AST_OPCODE: assert property (
        issue_q && !dec_q.two_word |-> dec_q.opcode == $past(opc)
    ) else $error("opcode not taken from top byte");

    AST_TWO_WORD: assert property (
        take_first && is_two |=> ##3 (cyc_stb && state_q == decode_pkg::ST_WORD2)
            ##1 (issue_q && done_q && cycles_q == 2'h2)
    ) else $error("two-word instruction not two cycles");

    AST_NOP_KEEPS: assert property (
        nop_o && !wr_flag |=> flags_q == $past(flags_q)
    ) else $error("flags changed in a no-op cycle");

    AST_DEST: assert property (
        issue_q && !dec_q.two_word |-> dec_q.dest_file == $past(word_i[decode_pkg::D_BIT])
    ) else $error("destination select wrong");

    AST_BITSEL: assert property (
        issue_q && dec_q.mode == decode_pkg::MODE_BYTE |-> !dec_q.bit_sel[3]
    ) else $error("byte bit select above 7");

    AST_U10: assert property (
        issue_q && dec_q.mode == decode_pkg::MODE_BYTE
            && dec_q.ten_bit_unsigned_operand > decode_pkg::U10_BYTE_MAX |-> dec_q.err_range
    ) else $error("byte literal above 255 not flagged");

    AST_EVEN: assert property (
        issue_q && dec_q.two_word |-> dec_q.err_addr == $past(word_i[0], 5)
    ) else $error("odd program address not flagged");

    AST_S10: assert property (
        issue_q && !dec_q.two_word |-> dec_q.ten_bit_signed_operand ==
            16'($signed($past(word_i[decode_pkg::U10_HI:decode_pkg::U10_LO])))
    ) else $error("signed operand out of range");

    AST_SKIP: assert property (
        done_q |-> (cycles_q == 2'h3) == $past(state_q == decode_pkg::ST_SKIP2)
    ) else $error("skip cycle count wrong");

    AST_FLUSH: assert property (
        take_first && is_alw |=> ##4 (done_q && cycles_q == 2'h2)
    ) else $error("fixed two-cycle instruction wrong");

    AST_MAC_WR: assert property (
        issue_q && !dec_q.two_word |-> dec_q.mac_wr_en == (^$past(word_i[decode_pkg::MWR_HI:0]))
            && dec_q.mac_result_writeback_reg == decode_pkg::MAC_WR_REG
    ) else $error("write-back not to W13");

    COV_TWO: cover property (issue_q && dec_q.two_word);
    COV_SKIP3: cover property (done_q && cycles_q == 2'h3);
    COV_FLUSH: cover property (done_q && cycles_q == 2'h2 && !dec_q.two_word);
endmodule : instr_decode
`default_nettype wire

/* bench/prog_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Program memory and branch outcome model
// ----------------------------------------
module prog_mem_model (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic fetch_i,
    output logic [23:0] word_o,
    output logic cond_o,
    output logic chg_o
);
    // Each slot: change-PC flag, condition flag, program word
    logic [25:0] mem [64];
    logic [5:0] pc_q;

    // PC moves only on a consumed word, so a word is never fetched twice
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_q <= 6'h00;
        end else if (fetch_i) begin
            pc_q <= pc_q + 6'h01;
        end
    end

    // Outcome travels with the word, as the datapath would report it
    assign {chg_o, cond_o, word_o} = mem[pc_q];
endmodule : prog_mem_model
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module testbench;
    logic mclk_i, rst_n_i, fetch_o, cond_true_i, pc_change_i, cyc_stb_o, issue_o;
    logic nop_o, done_o, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
    logic [23:0] word_i;
    logic [1:0] phase_o, cycles_o;
    logic [7:0] paddr_i, op;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [8:0] v;
    decode_pkg::flags_t flag_val_i, flag_we_i, flags_o, hold;
    decode_pkg::dec_t dec_o;
    logic [23:0] q1 [$];
    logic [23:0] q2 [$];
    logic [1:0] qc [$];
    int n_errors, num_checks, seed, cyc, gap, n;

    instr_decode u_instr_decode (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .word_i(word_i),
        .fetch_o(fetch_o), .cond_true_i(cond_true_i), .pc_change_i(pc_change_i),
        .flag_val_i(flag_val_i), .flag_we_i(flag_we_i), .cyc_stb_o(cyc_stb_o),
        .phase_o(phase_o), .issue_o(issue_o), .dec_o(dec_o), .nop_o(nop_o),
        .done_o(done_o), .cycles_o(cycles_o), .flags_o(flags_o), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o));
    prog_mem_model u_prog_mem_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .fetch_i(fetch_o),
        .word_o(word_i), .cond_o(cond_true_i), .chg_o(pc_change_i));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task finish_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // Class of an opcode: 1 two-word, 2 always two cycles, 3 skip, 0 plain
    function automatic int kind(input logic [7:0] o);
        for (int i = 0; i < decode_pkg::N_TWO; i++) if (o === decode_pkg::OPC_TWO[i]) return 1;
        for (int i = 0; i < decode_pkg::N_ALW; i++) if (o === decode_pkg::OPC_ALW[i]) return 2;
        for (int i = 0; i < decode_pkg::N_SKIP; i++) if (o === decode_pkg::OPC_SKIP[i]) return 3;
        return 0;
    endfunction : kind

    task automatic put(input logic [23:0] w, input logic c, input logic g);
        u_prog_mem_model.mem[n] = {g, c, w};
        n++;
    endtask : put

    // Words skipped by a taken skip are stored but never expected to issue
    task automatic add(input logic [7:0] o, input logic c, input logic ex);
        logic [23:0] w1;
        logic [23:0] w2;
        logic [7:0] nx;
        int k;
        w1 = 24'($random(seed));
        w1[23:16] = o;
        w2 = 24'($random(seed));
        w2[23:16] = 8'h00;
        k = kind(o);
        nx = ($random(seed) & 1) ? decode_pkg::OPC_TWO[0] : 8'h10;
        put(w1, (k == 0 || k == 3) && c, k == 0 && c && w1[0]);
        if (k == 1) put(w2, 1'b0, 1'b0);
        if (ex) begin
            q1.push_back(w1);
            q2.push_back(w2);
            qc.push_back((k == 3 && c) ? ((kind(nx) == 1) ? 2'h3 : 2'h2)
                : ((k == 1 || k == 2 || c) ? 2'h2 : 2'h1));
        end
        if (k == 3 && c) add(nx, 1'b0, 1'b0);
    endtask : add

    // One APB transfer; held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        @(posedge mclk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do @(posedge mclk_i); while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic chk_dec(input logic [23:0] w1, input logic [23:0] w2);
        logic bm;
        bm = (w1[15:14] == decode_pkg::MODE_BYTE);
        `CHK("opcode", w1[23:16], dec_o.opcode)
        `CHK("two_word", kind(w1[23:16]) == 1, dec_o.two_word)
        `CHK("nop", w1[23:16] == decode_pkg::OPC_NOP, dec_o.nop)
        `CHK("dest", w1[13], dec_o.dest_file)
        `CHK("default_work_register", decode_pkg::DEF_DEFAULT_WORK_REGISTER, dec_o.default_work_register)
        `CHK("faddr", w1[12:0], dec_o.file_addr)
        `CHK("mode", w1[15:14], dec_o.mode)
        `CHK("bitsel", bm ? {1'b0, w1[2:0]} : w1[3:0], dec_o.bit_sel)
        `CHK("u10", w1[13:4], dec_o.ten_bit_unsigned_operand)
        `CHK("range", bm && w1[13:4] > 10'h0FF, dec_o.err_range)
        `CHK("s5", {{11{w1[4]}}, w1[4:0]}, dec_o.s5_ext)
        `CHK("s10", {{6{w1[13]}}, w1[13:4]}, dec_o.ten_bit_signed_operand)
        `CHK("s16", w1[15:0], dec_o.s16)
        `CHK("mac", w1[15:2], {dec_o.acc_b, dec_o.mul_pair, dec_o.x_op, dec_o.x_dst,
            dec_o.y_op, dec_o.y_dst})
        `CHK("mac_wr", {w1[1] ^ w1[0], w1[1:0] == 2'h2, &w1[1:0]},
            {dec_o.mac_wr_en, dec_o.mac_wr_inc, dec_o.err_mac})
        if (kind(w1[23:16]) == 1) begin
            `CHK("paddr", {w2[6:0], w1[15:0]}, dec_o.program_address_operand)
            `CHK("odd", w1[0], dec_o.err_addr)
        end
    endtask : chk_dec

    // ----------------------------------------
    // Clock, timeout and monitors
    // ----------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    // Ceiling far above the few hundred cycles the program needs
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            finish_test();
        end
    end

    // Strobe spacing, decoded fields in issue order, cycle counts in done order
    always @(posedge mclk_i) if (rst_n_i) begin
        if (cyc_stb_o === 1'b1) begin
            if (gap != 0) `CHK("gap", 4, gap)
            `CHK("phase", 2'h3, phase_o)
            gap = 1;
        end else if (gap != 0) gap++;
        if (issue_o === 1'b1 && q1.size() != 0) begin
            chk_dec(q1.pop_front(), q2.pop_front());
        end
        if (done_o === 1'b1 && qc.size() != 0) `CHK("cycles", qc.pop_front(), cycles_o)
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 32'h9BCA;
        rst_n_i <= 1'b0; // Scheduled so the reset edge is seen at time zero
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        flag_val_i = '0;
        flag_we_i = '0;
        for (int i = 0; i < 64; i++) u_prog_mem_model.mem[i] = 26'h010_0000; // Plain filler
        add(decode_pkg::OPC_NOP, 1'b0, 1'b1);
        for (int i = 0; i < decode_pkg::N_ALW; i++) add(decode_pkg::OPC_ALW[i], 1'b0, 1'b1);
        for (int i = 0; i < decode_pkg::N_TWO; i++) add(decode_pkg::OPC_TWO[i], 1'b0, 1'b1);
        for (int i = 0; i < 8; i++) add(decode_pkg::OPC_SKIP[i % 4], 1'(i < 6), 1'b1);
        for (int i = 0; i < 12; i++) begin
            do op = 8'($random(seed)); while (kind(op) != 0 || op == 8'h00);
            add(op, 1'($random(seed)), 1'b1);
        end
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        `CHK("flags_rst", 9'h000, flags_o)
        while (qc.size() != 0) @(posedge mclk_i);
        `CHK("issued", 0, q1.size())
        $display("test decode done");
        for (int i = 0; i < 4; i++) begin
            v = 9'($random(seed));
            apb(1'b1, decode_pkg::FLAG_OFS, {23'h0, v}, rd, err);
            apb(1'b0, decode_pkg::FLAG_OFS, 32'h0, rd, err);
            `CHK("flags_rd", {23'h0, v}, rd)
            `CHK("flags_o", v, flags_o)
        end
        apb(1'b0, 8'hFC, 32'h0, rd, err);
        `CHK("unmapped_err", 1'b1, err)
        `CHK("unmapped_rd", 32'h0, rd)
        apb(1'b1, decode_pkg::CTRL_OFS, 32'h0, rd, err);
        repeat (8) @(posedge mclk_i);
        `CHK("halt_nop", 1'b1, nop_o)
        hold = flags_o;
        flag_val_i <= ~hold;
        flag_we_i <= 9'h1FF;
        repeat (4) @(posedge mclk_i);
        `CHK("nop_flags", hold, flags_o)
        // Resume on plain filler words; sticky zero only stays set by a zero result
        v = 9'($random(seed));
        hold = decode_pkg::flags_t'(v & {4'hF, flags_o.sticky_zero_flag, 4'hF});
        flag_val_i <= v;
        apb(1'b1, decode_pkg::CTRL_OFS, 32'h1, rd, err);
        do @(posedge mclk_i); while (nop_o !== 1'b0);
        @(posedge mclk_i);
        `CHK("dp_flags", hold, flags_o)
        flag_we_i <= 9'h000;
        $display("test flags done");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
